// ### hdl/vadd_top.sv
/*
 * Voice activity decision: threshold adaptation, raw decision, hangover,
 * periodicity. Assumes a one-cycle frame strobe every 20 ms from the encoder.
 */
// Overview of operation
// R1: adapt threshold at most once per 20 ms frame.
// R2: low frame energy forces threshold to floor, autocorr kept.
// R3: adapt only when steady, not periodic, no info tone.
// R4: adaptation copies predictor autocorr into adaptive autocorr.
// R5: scale threshold down by 1/32; keep if above energy times gain.
// R6: else take min of raised value and energy times gain.
// R7: cap threshold at filtered energy plus upper margin.
// R8: reset threshold, autocorr entry zero to six, counter clear.
// R9: raw decision when filtered energy exceeds threshold.
// R10: burst counter, saturating at three, loads hold of ten.
// R11: final decision is raw or hold active; hold decrements.
// R12: reset burst zero and hold minus one.
// R13: count lag pairs closer than two.
// R14: shift pair counts; periodic when sum at least four.
// R15: last lag kept as next lag zero, initially 18.
// R16: periodicity updated after decision using current lags.
// R17: encoder supplies inputs first; decision uses previous periodic flag.
// R18: reset restores all state, periodic flag set.
// R19: energies and threshold in pseudo-float format.
// R20: frame inputs on valid strobe; decision returned with valid.
`timescale 1ns/10ps
`default_nettype none
module vadd_top
   import vadd_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic FRAME_VALID,
   input wire vadd_frame_t FRAME_IN,
   input wire logic LAG_VALID,
   input wire logic [7:0] LAG_FIRST,
   input wire logic [7:0] LAG_SECOND,
   output logic DECISION_VALID,
   output logic FINAL_DECISION,
   output logic RAW_DECISION,
   output logic PERIODIC_FLAG,
   output vadd_pf_t DECISION_THRESHOLD,
   output logic [VADD_ACF_NUM*VADD_AUTO_W-1:0] ADAPTIVE_AUTOCORR,
   output logic [7:0] ADAPT_COUNT
);
   typedef enum {VADD_IDLE, VADD_FALL, VADD_RISE, VADD_CAP, VADD_DECIDE} vadd_state_t;

   vadd_state_t state_r;
   vadd_frame_t frame_r;
   vadd_pf_t thresh_r;
   logic [2:0] burst_r;
   logic signed [4:0] hold_r;
   logic periodic;
   logic raw;
   logic adapt_ok;
   logic adapt_r;
   logic burst_hit;

   vadd_pf_t scaled_thr;
   vadd_pf_t target;
   vadd_pf_t limit;
   logic thr_gt_target;
   logic up_gt_target;
   logic thr_gt_limit;
   logic thr_gt_energy;
   logic [15:0] thr_gain;
   logic low_energy;
   logic fe_gt_floor;

   // Threshold scaling: fall uses (1-1/32), rise uses (1+1/16) in Q14.
   always_comb begin
      if (state_r == VADD_FALL) begin
         thr_gain = 16'h4000 - (16'h4000 >> VADD_FALL_SHIFT);
      end else begin
         thr_gain = 16'h4000 + (16'h4000 >> VADD_RISE_SHIFT);
      end
   end

   vadd_pfmath u_thr (
      .a(thresh_r),
      .b(target),
      .gain_q14(thr_gain),
      .scaled(scaled_thr),
      .sum(),
      .a_gt_b(thr_gt_target)
   );

   vadd_pfmath u_energy (
      .a(frame_r.filt_energy),
      .b(VADD_UPPER_MARGIN),
      .gain_q14(VADD_STEADY_GAIN_Q14),
      .scaled(target),
      .sum(limit),
      .a_gt_b()
   );

   vadd_pfmath u_cap (
      .a(thresh_r),
      .b(limit),
      .gain_q14(16'h4000),
      .scaled(),
      .sum(),
      .a_gt_b(thr_gt_limit)
   );

   vadd_pfmath u_dec (
      .a(frame_r.filt_energy),
      .b(thresh_r),
      .gain_q14(16'h4000),
      .scaled(),
      .sum(),
      .a_gt_b(thr_gt_energy)
   );

   vadd_pfmath u_floor (
      .a(VADD_ENERGY_FLOOR),
      .b(frame_r.frame_energy),
      .gain_q14(16'h4000),
      .scaled(),
      .sum(),
      .a_gt_b(fe_gt_floor)
   );

   // R6: raised value against target
   vadd_pfmath u_rise (
      .a(scaled_thr),
      .b(target),
      .gain_q14(16'h4000),
      .scaled(),
      .sum(),
      .a_gt_b(up_gt_target)
   );

   assign low_energy = fe_gt_floor;
   // R9: strict compare
   assign raw = thr_gt_energy;
   // R3: adapt only in quiet
   assign adapt_ok = !low_energy && frame_r.steady_spectrum && !periodic
                     && !frame_r.info_signal;
   // R10: burst limit reached
   assign burst_hit = raw && ((burst_r + 3'h1) >= VADD_BURST_LIMIT);

   // Keeps the fall step's choice, so the rise and cap steps act only on an adaptation.
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         adapt_r <= 1'b0;
      end else if (state_r == VADD_FALL) begin
         adapt_r <= adapt_ok;
      end
   end

   // R20: capture frame on strobe
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         frame_r <= '0;
      end else if (FRAME_VALID && state_r == VADD_IDLE) begin
         frame_r <= FRAME_IN;
      end
   end

   // R1: one pass per frame
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_r <= VADD_IDLE;
      end else begin
         case (state_r)
            VADD_IDLE: begin
               if (FRAME_VALID) begin
                  state_r <= VADD_FALL;
               end
            end
            VADD_FALL: begin
               // Every frame walks all steps, so the answer always comes at the same latency.
               state_r <= VADD_RISE;
            end
            VADD_RISE: state_r <= VADD_CAP;
            VADD_CAP: state_r <= VADD_DECIDE;
            VADD_DECIDE: state_r <= VADD_IDLE;
            default: state_r <= VADD_IDLE;
         endcase
      end
   end

   // R19: threshold as pseudo-float
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         // R8: reset threshold
         thresh_r <= VADD_THRESH_INIT;
      end else begin
         case (state_r)
            VADD_FALL: begin
               if (low_energy) begin
                  // R2: force floor
                  thresh_r <= VADD_THRESH_FLOOR;
               end else if (adapt_ok) begin
                  // R5: trial decrease
                  thresh_r <= scaled_thr;
               end
            end
            VADD_RISE: begin
               // R6: bounded increase
               if (adapt_r && !thr_gt_target) begin
                  if (up_gt_target) begin
                     thresh_r <= target;
                  end else begin
                     thresh_r <= scaled_thr;
                  end
               end
            end
            VADD_CAP: begin
               // R7: upper cap
               if (adapt_r && thr_gt_limit) begin
                  thresh_r <= limit;
               end
            end
            default: thresh_r <= thresh_r;
         endcase
      end
   end

   // R4: copy predictor autocorr on adaptation
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ADAPTIVE_AUTOCORR <= {{(VADD_ACF_NUM-1)*VADD_AUTO_W{1'b0}}, VADD_ADAPT_AUTO0_INIT};
         ADAPT_COUNT <= 8'h00;
      end else if (state_r == VADD_FALL && adapt_ok) begin
         ADAPTIVE_AUTOCORR <= frame_r.predictor_autocorr;
         ADAPT_COUNT <= ADAPT_COUNT + 8'h01;
      end
   end

   // R20: one-cycle answer strobe
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         DECISION_VALID <= 1'b0;
      end else begin
         DECISION_VALID <= (state_r == VADD_DECIDE);
      end
   end

   // R10: burst counter
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         // R12: no burst at start
         burst_r <= 3'h0;
      end else if (state_r == VADD_DECIDE) begin
         if (burst_hit) begin
            burst_r <= VADD_BURST_LIMIT;
         end else begin
            burst_r <= raw ? burst_r + 3'h1 : 3'h0;
         end
      end
   end

   // R11: hangover countdown
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         // R12: hangover idle
         hold_r <= VADD_HOLD_INIT;
      end else if (state_r == VADD_DECIDE) begin
         if (burst_hit) begin
            // Loaded and decremented in the same frame, so it reads one below the length.
            hold_r <= VADD_HOLD_LENGTH - 5'sh01;
         end else if (hold_r >= 5'sh00) begin
            hold_r <= hold_r - 5'sh01;
         end
      end
   end

   // R11: raw or hold active
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         RAW_DECISION <= 1'b0;
         FINAL_DECISION <= 1'b0;
      end else if (state_r == VADD_DECIDE) begin
         // Both decisions stand until the decide step of the next frame.
         RAW_DECISION <= raw;
         FINAL_DECISION <= raw || (hold_r >= 5'sh00);
      end
   end

   assign periodic = PERIODIC_FLAG;
   // The published threshold trails the working one by a cycle in every state, so the fall and rise values show too.
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         DECISION_THRESHOLD <= VADD_THRESH_INIT;
      end else begin
         DECISION_THRESHOLD <= thresh_r;
      end
   end

   // R16: periodicity after decision
   // R17: decision reads previous flag
   vadd_period u_period (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .lag_valid(LAG_VALID),
      .lag_first(LAG_FIRST),
      .lag_second(LAG_SECOND),
      .periodic_r(PERIODIC_FLAG)
   );
endmodule : vadd_top
`default_nettype wire

// ### hdl/vadd_pkg.sv
/*
 * Shared constants and carrier types for the voice activity decision block.
 * Assumes pseudo-floating values arrive already normalised from the encoder.
 */
package vadd_pkg;

   // Pseudo-floating value: 16-bit signed exponent and a 16-bit mantissa >= 0x4000.
   typedef struct packed {
      logic signed [15:0] exp;
      logic [15:0] man;
   } vadd_pf_t;

   localparam int VADD_FRAME_MS = 20;
   localparam int VADD_ACF_NUM = 9;
   localparam int VADD_RC_NUM = 4;
   localparam int VADD_AUTO_W = 32;

   // Energy floor 130000 and threshold floor 346667 in pseudo-float form.
   localparam vadd_pf_t VADD_ENERGY_FLOOR = '{exp: 16'sh0011, man: 16'h7EF4};
   localparam vadd_pf_t VADD_THRESH_FLOOR = '{exp: 16'sh0013, man: 16'h54A3};
   // Upper margin 69333340.
   localparam vadd_pf_t VADD_UPPER_MARGIN = '{exp: 16'sh001B, man: 16'h421F};
   // Threshold at reset 866656.
   localparam vadd_pf_t VADD_THRESH_INIT = '{exp: 16'sh0014, man: 16'h69CB};
   localparam logic [31:0] VADD_ADAPT_AUTO0_INIT = 32'h0000_0006;

   localparam int VADD_FALL_SHIFT = 5;
   localparam int VADD_RISE_SHIFT = 4;
   // Steady gain 2.1 as Q14 multiplier.
   localparam logic [15:0] VADD_STEADY_GAIN_Q14 = 16'h8666;

   localparam logic [2:0] VADD_BURST_LIMIT = 3'h3;
   localparam logic signed [4:0] VADD_HOLD_LENGTH = 5'sh0A;
   localparam logic signed [4:0] VADD_HOLD_INIT = -5'sh01;

   localparam logic [7:0] VADD_LAG_INIT = 8'h12;
   localparam logic [7:0] VADD_PAIR_GAP_LIMIT = 8'h02;
   localparam logic [2:0] VADD_PAIR_SUM_LIMIT = 3'h4;

   typedef struct packed {
      vadd_pf_t filt_energy;
      vadd_pf_t frame_energy;
      logic [VADD_ACF_NUM*VADD_AUTO_W-1:0] predictor_autocorr;
      logic steady_spectrum;
      logic info_signal;
   } vadd_frame_t;

endpackage : vadd_pkg

// ### hdl/vadd_pfmath.sv
/*
 * Pseudo-floating helpers: compare, scale by a Q14 factor, and add.
 * Assumes normalised operands; results are renormalised in one cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module vadd_pfmath
   import vadd_pkg::*;
(
   input wire vadd_pf_t a,
   input wire vadd_pf_t b,
   input wire logic [15:0] gain_q14,
   output vadd_pf_t scaled,
   output vadd_pf_t sum,
   output logic a_gt_b
);
   logic [31:0] prod;
   logic [15:0] acc;
   logic [15:0] al;
   logic [15:0] bl;
   logic signed [15:0] diff;

   always_comb begin
      // Exponents decide first since mantissas are normalised.
      if (a.exp != b.exp) begin
         a_gt_b = (a.exp > b.exp);
      end else begin
         a_gt_b = (a.man > b.man);
      end
      prod = a.man * gain_q14;
      // The top set bit of the product puts the mantissa back into 0x4000..0x7FFF.
      if (prod[31]) begin
         scaled = '{exp: a.exp + 16'sh0003, man: {1'b0, prod[31:17]}};
      end else if (prod[30]) begin
         scaled = '{exp: a.exp + 16'sh0002, man: {1'b0, prod[30:16]}};
      end else if (prod[29]) begin
         scaled = '{exp: a.exp + 16'sh0001, man: {1'b0, prod[29:15]}};
      end else if (prod[28]) begin
         scaled = '{exp: a.exp, man: {1'b0, prod[28:14]}};
      end else begin
         scaled = '{exp: a.exp - 16'sh0001, man: {1'b0, prod[27:13]}};
      end
      diff = a.exp - b.exp;
      al = a.man;
      bl = b.man;
      if (diff >= 16'sh0010) begin
         bl = 16'h0000;
      end else if (diff > 16'sh0000) begin
         bl = b.man >> diff[3:0];
      end else if (diff <= -16'sh0010) begin
         al = 16'h0000;
      end else if (diff < 16'sh0000) begin
         al = a.man >> 4'((-diff));
      end
      acc = al + bl;
      sum.exp = (diff > 16'sh0000) ? a.exp : b.exp;
      sum.man = acc;
      // Both mantissas stay below 0x8000, so a carry shows up in bit 15.
      if (acc[15]) begin
         sum.exp = sum.exp + 16'sh0001;
         sum.man = {1'b0, acc[15:1]};
      end
   end
endmodule : vadd_pfmath
`default_nettype wire

// ### hdl/vadd_period.sv
/*
 * Periodicity tracker fed with the two pitch lags of each frame.
 * Assumes a one-cycle lag strobe, given after the frame's decision.
 */
`timescale 1ns/10ps
`default_nettype none
module vadd_period
   import vadd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic lag_valid,
   input wire logic [7:0] lag_first,
   input wire logic [7:0] lag_second,
   output logic periodic_r
);
   logic [7:0] lag_zero_r;
   logic [1:0] prior_pair_count_r;
   logic [1:0] second_prior_pair_count_r;
   logic [1:0] close_pair_count;
   logic [7:0] gap_a;
   logic [7:0] gap_b;

   always_comb begin
      gap_a = (lag_first > lag_zero_r) ? lag_first - lag_zero_r : lag_zero_r - lag_first;
      gap_b = (lag_second > lag_first) ? lag_second - lag_first : lag_first - lag_second;
      // R13: count close pairs
      close_pair_count = {1'b0, gap_a < VADD_PAIR_GAP_LIMIT}
                       + {1'b0, gap_b < VADD_PAIR_GAP_LIMIT};
   end

   // R18: reset history
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lag_zero_r <= VADD_LAG_INIT;
         prior_pair_count_r <= 2'h0;
         second_prior_pair_count_r <= 2'h0;
         periodic_r <= 1'b1;
      end else if (lag_valid) begin
         // R15: keep last lag
         lag_zero_r <= lag_second;
         // R14: shift and sum
         second_prior_pair_count_r <= prior_pair_count_r;
         prior_pair_count_r <= close_pair_count;
         periodic_r <= ({1'b0, prior_pair_count_r} + {1'b0, close_pair_count})
                       >= VADD_PAIR_SUM_LIMIT;
      end
   end
endmodule : vadd_period
`default_nettype wire

// ### verification/vadd_chk.sv
/* Port checker for vadd_top, bound into it.
   Assumes the frame and lag timing agreed for this block. */
`timescale 1ns/10ps
`default_nettype none
module vadd_chk
   import vadd_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic FRAME_VALID,
   input wire logic LAG_VALID,
   input wire logic DECISION_VALID,
   input wire logic FINAL_DECISION,
   input wire logic RAW_DECISION,
   input wire logic PERIODIC_FLAG,
   input wire logic [VADD_ACF_NUM*VADD_AUTO_W-1:0] ADAPTIVE_AUTOCORR,
   input wire logic [7:0] ADAPT_COUNT
);
   logic [2:0] busy_r;
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (SYS_RST);
   // Strobes inside this count are refused, so they must not start a frame.
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         busy_r <= 3'h0;
      end else if (FRAME_VALID && busy_r == 3'h0) begin
         busy_r <= 3'h4;
      end else if (busy_r != 3'h0) begin
         busy_r <= busy_r - 3'h1;
      end
   end
   answer_latency_a: assert property (FRAME_VALID && busy_r == 3'h0 |-> ##5 DECISION_VALID)
      else $error("no decision five cycles after a frame");
   valid_pulse_a: assert property (DECISION_VALID |=> !DECISION_VALID)
      else $error("decision strobe longer than one cycle");
   valid_cause_a: assert property (DECISION_VALID |-> $past(FRAME_VALID, 5))
      else $error("decision strobe without a frame");
   final_has_raw_a: assert property (DECISION_VALID && RAW_DECISION |-> FINAL_DECISION)
      else $error("final decision lost an active raw decision");
   decision_hold_a: assert property (
      !DECISION_VALID |-> $stable({FINAL_DECISION, RAW_DECISION}))
      else $error("decision changed between frames");
   periodic_hold_a: assert property (
      !LAG_VALID && !$past(LAG_VALID) |-> $stable(PERIODIC_FLAG))
      else $error("periodic flag changed without lags");
   one_adapt_a: assert property (
      $changed(ADAPT_COUNT) |-> ADAPT_COUNT == $past(ADAPT_COUNT) + 8'h01 && busy_r >= 3'h3)
      else $error("adaptation count moved outside one frame step");
   autocorr_with_count_a: assert property (
      $changed(ADAPTIVE_AUTOCORR) |-> $changed(ADAPT_COUNT))
      else $error("adaptive autocorr changed without adaptation");
endmodule : vadd_chk
bind vadd_top vadd_chk u_chk (.SYS_CLK, .SYS_RST, .FRAME_VALID, .LAG_VALID, .DECISION_VALID,
   .FINAL_DECISION, .RAW_DECISION, .PERIODIC_FLAG, .ADAPTIVE_AUTOCORR, .ADAPT_COUNT);
`default_nettype wire

// ### verification/vadd_enc_model.sv
/* Encoder-side model: one frame strobe, wait for the decision, then the lags.
   Assumes the design answers within ten cycles of a frame. */
`timescale 1ns/10ps
`default_nettype none
module vadd_enc_model
   import vadd_pkg::*;
(
   input wire logic clk,
   input wire logic decision_valid,
   output var logic frame_valid,
   output var vadd_frame_t frame_in,
   output var logic lag_valid,
   output var logic [7:0] lag_first,
   output var logic [7:0] lag_second
);
   initial begin
      frame_valid = 1'b0;
      frame_in = '0;
      lag_valid = 1'b0;
      lag_first = 8'h00;
      lag_second = 8'h00;
   end
   task automatic send_frame(input vadd_frame_t f, output bit ok);
      ok = 1'b0;
      @(posedge clk);
      frame_valid <= 1'b1;
      frame_in <= f;
      @(posedge clk);
      frame_valid <= 1'b0;
      // Released data is scrambled so stale values cannot be relied on.
      frame_in <= ~f;
      for (int i = 0; i < 10 && !ok; i++) begin
         @(posedge clk);
         #1;
         ok = (decision_valid === 1'b1);
      end
   endtask : send_frame
   task automatic send_lags(input logic [7:0] l1, input logic [7:0] l2);
      @(posedge clk);
      lag_valid <= 1'b1;
      lag_first <= l1;
      lag_second <= l2;
      @(posedge clk);
      lag_valid <= 1'b0;
      lag_first <= ~l1;
      lag_second <= ~l2;
      @(posedge clk);
      #1;
   endtask : send_lags
endmodule : vadd_enc_model
`default_nettype wire

// ### verification/tb_top.sv
/* Self-checking bench for vadd_top driven through the encoder model.
   Assumes a decision five cycles after each frame. */
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import vadd_pkg::*;
;
   typedef logic [VADD_ACF_NUM*VADD_AUTO_W-1:0] vadd_ac_t;
   logic SYS_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic frame_valid, lag_valid, decision_valid, final_decision, raw_decision, periodic_flag;
   vadd_frame_t frame_in;
   vadd_pf_t threshold;
   logic [7:0] lag_first, lag_second, adapt_count;
   logic [7:0] exp_count = 8'h00;
   logic [7:0] lag0 = VADD_LAG_INIT;
   vadd_ac_t adaptive_ac;
   vadd_ac_t exp_ac = vadd_ac_t'(VADD_ADAPT_AUTO0_INIT);
   logic exp_per = 1'b1;
   int miscompares = 0;
   int total_checks = 0;
   int burst = 0;
   int hold = -1;
   int old_cnt = 0;
   bit ok;
   always #4 SYS_CLK = ~SYS_CLK;
   vadd_top dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .FRAME_VALID(frame_valid),
      .FRAME_IN(frame_in), .LAG_VALID(lag_valid), .LAG_FIRST(lag_first),
      .LAG_SECOND(lag_second), .DECISION_VALID(decision_valid), .FINAL_DECISION(final_decision),
      .RAW_DECISION(raw_decision), .PERIODIC_FLAG(periodic_flag),
      .DECISION_THRESHOLD(threshold), .ADAPTIVE_AUTOCORR(adaptive_ac), .ADAPT_COUNT(adapt_count));
   vadd_enc_model enc (.clk(SYS_CLK), .decision_valid(decision_valid), .frame_valid(frame_valid),
      .frame_in(frame_in), .lag_valid(lag_valid), .lag_first(lag_first), .lag_second(lag_second));
   task automatic check(input bit good, input string what);
      total_checks++;
      if (!good) begin
         miscompares++;
         $display("CHECK FAILED at %0t ns: %s", $time, what);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic run_frame(input logic [15:0] fe, input logic [15:0] fm, input logic [15:0] ee,
         input logic st, input logic inf, input logic [7:0] l1, input logic [7:0] l2,
         input logic [15:0] te, input logic [15:0] tm);
      vadd_frame_t f;
      logic adapt, raw;
      int d1, d2, cnt;
      f.filt_energy = '{exp: fe, man: fm};
      f.frame_energy = '{exp: ee, man: 16'h4000};
      f.predictor_autocorr = {VADD_ACF_NUM{24'h11_1100, l1}};
      f.steady_spectrum = st;
      f.info_signal = inf;
      adapt = ee > VADD_ENERGY_FLOOR.exp && st && !inf && !exp_per;
      if (adapt) begin
         exp_ac = f.predictor_autocorr;
         exp_count = exp_count + 8'h01;
      end
      enc.send_frame(f, ok);
      check(ok, "no decision strobe");
      if (!ok) begin
         tally_and_finish();
      end
      raw = fe > te || (fe == te && fm > tm);
      burst = raw ? burst + 1 : 0;
      if (burst >= VADD_BURST_LIMIT) begin
         hold = VADD_HOLD_LENGTH;
         burst = VADD_BURST_LIMIT;
      end
      check(raw_decision === raw, "raw decision");
      check(final_decision === (raw || hold >= 0), "final decision");
      if (hold >= 0) begin
         hold--;
      end
      @(posedge SYS_CLK);
      #1;
      // Rounding of the scaling steps may differ by a few mantissa steps.
      ok = threshold.exp === te && threshold.man <= tm + 16'h4 && threshold.man + 16'h4 >= tm;
      check(ok, "threshold");
      check(adaptive_ac === exp_ac && adapt_count === exp_count, "adaptive state");
      enc.send_lags(l1, l2);
      d1 = int'(l1) - int'(lag0);
      d2 = int'(l2) - int'(l1);
      cnt = int'(d1 * d1 < 4) + int'(d2 * d2 < 4);
      exp_per = cnt + old_cnt >= VADD_PAIR_SUM_LIMIT;
      old_cnt = cnt;
      lag0 = l2;
      check(periodic_flag === exp_per, "periodic flag");
   endtask : run_frame
   initial begin
      repeat (20) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      @(posedge SYS_CLK);
      #1;
      check(threshold === VADD_THRESH_INIT && adaptive_ac === exp_ac, "reset threshold");
      check(adapt_count === 8'h00 && periodic_flag === 1'b1, "reset counters");
      check(final_decision === 1'b0 && decision_valid === 1'b0, "reset decision");
      $display("Test reset done");
      run_frame(16'h0005, 16'h4000, 16'h001E, 1'b1, 1'b0, 8'h28, 8'h50, 16'h0014, 16'h69CB);
      run_frame(16'h0005, 16'h4000, 16'h001E, 1'b1, 1'b0, 8'h52, 8'h54, 16'h0014, 16'h667D);
      run_frame(16'h0013, 16'h61A8, 16'h001E, 1'b1, 1'b0, 8'h54, 8'h55, 16'h0014, 16'h668A);
      run_frame(16'h0014, 16'h4000, 16'h001E, 1'b1, 1'b0, 8'h56, 8'h56, 16'h0014, 16'h698B);
      run_frame(16'h001E, 16'h4000, 16'h001E, 1'b1, 1'b0, 8'h5A, 8'h5F, 16'h0014, 16'h698B);
      run_frame(16'h001E, 16'h4000, 16'h001E, 1'b1, 1'b1, 8'h28, 8'h28, 16'h0014, 16'h698B);
      run_frame(16'h001E, 16'h4000, 16'h001E, 1'b0, 1'b0, 8'h28, 8'h28, 16'h0014, 16'h698B);
      run_frame(16'h0005, 16'h4000, 16'h0005, 1'b1, 1'b0, 8'h28, 8'h28, 16'h0013, 16'h54A3);
      $display("Test adaptation done");
      for (int i = 0; i < 10; i++) begin
         run_frame(16'h0005, 16'h4000, 16'h001E, 1'b1, 1'b1, 8'h28, 8'h28, 16'h0013, 16'h54A3);
      end
      $display("Test hangover done");
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
